/* hw/etl_defines.svh */
`ifndef ETL_DEFINES_SVH
`define ETL_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ETL_REG_RAW      4'h0
`define ETL_REG_BASE     4'h1
`define ETL_REG_ABS      4'h2
`define ETL_REG_CTRL     4'h3
`define ETL_REG_STATUS   4'h4
`define ETL_REG_AUTO     4'h5
// ----------------------------------------
// Limits and reset values
// ----------------------------------------
`define ETL_RAW_MIN      32'h0000_0001
`define ETL_RAW_MAX      32'h0000_0fff
`define ETL_RAW_RESET    32'h0000_0064
`define ETL_BASE_STD     32'h0000_0014
`define ETL_BASE_LONG    32'h0000_001f
`define ETL_STEP_STD     32'h0000_0001
`define ETL_STEP_LONG    32'h0000_001f
`define ETL_MAX_STD      32'h0098_9680
`define ETL_MAX_LONG     32'h0001_f000
`define ETL_MIN_STD      32'h0000_0018
`define ETL_MIN_LONG     32'h0000_007c
// Time-base unit is one microsecond
`define ETL_US_NS        32'h0000_03e8
`define ETL_CLK_NS       32'h0000_0008
// ----------------------------------------
// Control and status bits
// ----------------------------------------
`define ETL_CTRL_WIDTH   0
`define ETL_CTRL_AUTO    1
`define ETL_CTRL_START   2
`define ETL_ST_BUSY      0
`define ETL_ST_AUTO      1
`endif

/* hw/etl_pkg.sv */
package etl_pkg;
  typedef enum logic [1:0] {ETL_IDLE, ETL_TIMED, ETL_WIDTH} etl_state_t;
endpackage

/* hw/etl_us_tick.sv */
`timescale 1ns/1ns
`include "etl_defines.svh"
// Produces one pulse per microsecond of CLK
module etl_us_tick (
  input wire logic CLK,
  input wire logic RST,
  input wire logic run,
  output logic tick
);
  localparam logic [31:0] CYC = `ETL_US_NS / `ETL_CLK_NS;
  logic [31:0] cnt;
  wire last = (cnt == CYC - 32'h1);
  always_ff @(posedge CLK) begin
    if (RST || !run || last) cnt <= '0;
    else cnt <= cnt + 32'h1;
  end
  assign tick = run && last;
endmodule

/* hw/etl_top.sv */
`timescale 1ns/1ns
`include "etl_defines.svh"
// ----------------------------------------
// What this block does
// - Timed exposure length is the raw count times the selected time base, or the auto value in us when auto is on.
// - Raw count writes outside one to 4095 are not taken.
// - The time base resets to 20 us, or 31 us on the long-base variant.
// - The time base moves in 1 us steps, or 31 us steps on long base.
// - An absolute write in us is turned into a raw count on current base.
// - An absolute value past the raw range clamps to it; one whose rounded length breaks a limit is refused.
// - Raw or base writes refresh the readable absolute value.
// - Timed exposure is never shorter than the variant minimum, except auto from reset on long base, which starts at 24 us.
// - Timed exposure never exceeds 10000000 us, or 126976 us on long base.
// - The automatic exposure value keeps full microsecond resolution.
// - Automatic adjustment is off while width mode is selected.
// - In width mode exposure follows the external trigger level.
// ----------------------------------------
module etl_top
  import etl_pkg::*;
#(
  parameter bit LONG_BASE = 1'b0,
  parameter logic [31:0] MIN_US = LONG_BASE ? `ETL_MIN_LONG : `ETL_MIN_STD
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic EXTERNAL_ACQ_START_TRIGGER,
  input wire logic [31:0] AUTO_EXP_US,
  input wire logic AUTO_EXP_VALID,
  output logic EXPOSE
);
  localparam logic [31:0] BASE_RST = LONG_BASE ? `ETL_BASE_LONG
                                               : `ETL_BASE_STD;
  localparam logic [31:0] STEP = LONG_BASE ? `ETL_STEP_LONG : `ETL_STEP_STD;
  localparam logic [31:0] MAX_US = LONG_BASE ? `ETL_MAX_LONG : `ETL_MAX_STD;
  localparam logic [31:0] US_CYC = `ETL_US_NS / `ETL_CLK_NS;

  logic [31:0] raw;
  logic [31:0] base;
  logic [31:0] abs_us;
  logic [31:0] auto_us;
  logic width_mode;
  logic auto_en;
  etl_state_t state;
  logic [31:0] us_cnt;
  logic [31:0] base_cnt;
  logic trig_q;
  logic tick;
  logic [31:0] next_raw;
  logic [31:0] goal_q;
  logic [31:0] unit_q;
  logic [31:0] dur_cyc;

  // ----------------------------------------
  // Arithmetic helpers
  // ----------------------------------------
  function automatic logic [31:0] etl_mul(input logic [31:0] a,
                                          input logic [31:0] b);
    logic [63:0] p;
    p = 64'(a) * 64'(b);
    etl_mul = (p[63:32] != 32'h0) ? 32'hffff_ffff : p[31:0];
  endfunction

  // Nearest raw count for an absolute request, clamped to legal range
  // The sum is one bit wider so a request near the top cannot wrap
  // round to a short exposure
  function automatic logic [31:0] etl_to_raw(input logic [31:0] us,
                                             input logic [31:0] b);
    logic [32:0] s;
    logic [31:0] q;
    s = {1'b0, us} + {1'b0, b >> 1};
    q = 32'(s / {1'b0, b});
    if (q < `ETL_RAW_MIN) q = `ETL_RAW_MIN;
    if (q > `ETL_RAW_MAX) q = `ETL_RAW_MAX;
    etl_to_raw = q;
  endfunction

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire wr_raw = WR && ADDR == `ETL_REG_RAW;
  wire wr_base = WR && ADDR == `ETL_REG_BASE;
  wire wr_abs = WR && ADDR == `ETL_REG_ABS;
  wire wr_ctrl = WR && ADDR == `ETL_REG_CTRL;
  wire raw_ok = WDATA >= `ETL_RAW_MIN && WDATA <= `ETL_RAW_MAX;
  // Base must sit on the step grid and may not be zero on either variant
  wire base_ok = WDATA != 32'h0 && (WDATA % STEP) == 32'h0 &&
                 WDATA <= MAX_US;
  wire [31:0] abs_raw = etl_to_raw(WDATA, base);
  // Candidate duration after the write, checked against both limits
  wire [31:0] cand_raw = wr_raw ? WDATA : wr_abs ? abs_raw : raw;
  wire [31:0] cand_base = wr_base ? WDATA : base;
  wire [31:0] cand_dur = etl_mul(cand_raw, cand_base);
  wire dur_ok = cand_dur >= MIN_US && cand_dur <= MAX_US;
  wire take_raw = wr_raw && raw_ok && dur_ok;
  wire take_base = wr_base && base_ok && dur_ok;
  wire take_abs = wr_abs && dur_ok;
  wire busy = state != ETL_IDLE;

  // Raw count and base freeze during an exposure so a running count stays exact
  always_comb begin
    next_raw = raw;
    if (!busy && (take_raw || take_abs)) next_raw = cand_raw;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      raw <= `ETL_RAW_RESET;
      base <= BASE_RST;
      width_mode <= 1'b0;
      auto_en <= 1'b0;
    end else begin
      raw <= next_raw;
      if (take_base && !busy) base <= WDATA;
      if (wr_ctrl) width_mode <= WDATA[`ETL_CTRL_WIDTH];
      if (wr_ctrl) auto_en <= WDATA[`ETL_CTRL_AUTO] &&
                              !WDATA[`ETL_CTRL_WIDTH];
      else if (width_mode) auto_en <= 1'b0;
    end
  end

  // Absolute value always mirrors raw times base, so an uneven
  // request reads back as the rounded duration
  always_ff @(posedge CLK) begin
    if (RST) abs_us <= etl_mul(`ETL_RAW_RESET, BASE_RST);
    else abs_us <= etl_mul(next_raw,
                           (take_base && !busy) ? WDATA : base);
  end

  // Automatic value kept unquantised in microseconds
  always_ff @(posedge CLK) begin
    if (RST) auto_us <= `ETL_MIN_STD;
    else if (auto_en && AUTO_EXP_VALID) begin
      if (AUTO_EXP_US < MIN_US) auto_us <= MIN_US;
      else if (AUTO_EXP_US > MAX_US) auto_us <= MAX_US;
      else auto_us <= AUTO_EXP_US;
    end
  end

  // ----------------------------------------
  // Exposure timer
  // ----------------------------------------
  wire trig_rise = EXTERNAL_ACQ_START_TRIGGER && !trig_q;
  wire start = (trig_rise || (wr_ctrl && WDATA[`ETL_CTRL_START])) && !busy;
  // Timed length is raw count times base, or the auto length in us when that is on
  wire [31:0] goal = auto_en ? auto_us : raw;
  wire [31:0] goal_unit = auto_en ? 32'h1 : base;
  // Length is latched at start, so an auto update or a mode write
  // during an exposure can neither stretch nor cut it
  wire unit_end = us_cnt == unit_q - 32'h1;
  wire timed_end = tick && unit_end &&
                   base_cnt == goal_q - 32'h1;

  etl_us_tick u_tick (
    .CLK(CLK),
    .RST(RST),
    .run(state == ETL_TIMED),
    .tick(tick)
  );

  always_ff @(posedge CLK) begin
    if (RST) trig_q <= 1'b0;
    else trig_q <= EXTERNAL_ACQ_START_TRIGGER;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= ETL_IDLE;
      us_cnt <= '0;
      base_cnt <= '0;
      goal_q <= `ETL_RAW_RESET;
      unit_q <= BASE_RST;
    end else begin
      unique case (state)
        ETL_IDLE: begin
          us_cnt <= '0;
          base_cnt <= '0;
          goal_q <= goal;
          unit_q <= goal_unit;
          if (start) state <= width_mode ? ETL_WIDTH : ETL_TIMED;
        end
        ETL_TIMED: begin
          if (timed_end) state <= ETL_IDLE;
          else if (tick) begin
            if (unit_end) begin
              us_cnt <= '0;
              base_cnt <= base_cnt + 32'h1;
            end else us_cnt <= us_cnt + 32'h1;
          end
        end
        ETL_WIDTH: begin
          if (!EXTERNAL_ACQ_START_TRIGGER) state <= ETL_IDLE;
        end
        // The fourth code of the state register is never entered
        default: state <= ETL_IDLE;
      endcase
    end
  end

  assign EXPOSE = busy;

  // Cycles spent in the timed state, read only by the checks below
  always_ff @(posedge CLK) begin
    if (RST || state != ETL_TIMED) dur_cyc <= '0;
    else dur_cyc <= dur_cyc + 32'h1;
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire [31:0] rd_mux =
    ADDR == `ETL_REG_RAW ? raw :
    ADDR == `ETL_REG_BASE ? base :
    ADDR == `ETL_REG_ABS ? abs_us :
    ADDR == `ETL_REG_CTRL ? {30'h0, auto_en, width_mode} :
    ADDR == `ETL_REG_STATUS ? {30'h0, auto_en, busy} :
    ADDR == `ETL_REG_AUTO ? auto_us : 32'h0;

  always_ff @(posedge CLK) begin
    if (RST) RDATA <= '0;
    else if (RD) RDATA <= rd_mux;
    else RDATA <= '0;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_RAW_RANGE: assert property (@(posedge CLK) disable iff (RST)
    raw >= `ETL_RAW_MIN && raw <= `ETL_RAW_MAX)
    else $error("raw count out of range");
  AST_BASE_RESET: assert property (@(posedge CLK)
    $fell(RST) |-> base == BASE_RST)
    else $error("time base reset value wrong");
  AST_BASE_STEP: assert property (@(posedge CLK) disable iff (RST)
    (base % STEP) == 32'h0)
    else $error("time base off step grid");
  AST_ABS_TRACK: assert property (@(posedge CLK) disable iff (RST)
    abs_us == etl_mul(raw, base))
    else $error("absolute value not raw times base");
  AST_ABS_LOAD: assert property (@(posedge CLK) disable iff (RST)
    take_abs && !busy |=> raw == $past(abs_raw))
    else $error("absolute write did not load raw");
  AST_MIN_DUR: assert property (@(posedge CLK) disable iff (RST)
    $past(take_raw || take_abs || take_base) |-> abs_us >= MIN_US)
    else $error("exposure below minimum");
  AST_MAX_DUR: assert property (@(posedge CLK) disable iff (RST)
    $past(take_raw || take_abs || take_base) |-> abs_us <= MAX_US)
    else $error("exposure above maximum");
  AST_AUTO_OFF: assert property (@(posedge CLK) disable iff (RST)
    width_mode |-> !auto_en)
    else $error("auto enabled in width mode");
  AST_WIDTH_END: assert property (@(posedge CLK) disable iff (RST)
    state == ETL_WIDTH && !EXTERNAL_ACQ_START_TRIGGER |=> !EXPOSE)
    else $error("width exposure did not follow trigger");
  AST_TIMED_END: assert property (@(posedge CLK) disable iff (RST)
    state == ETL_TIMED && timed_end |=> state == ETL_IDLE)
    else $error("timed exposure did not end");
  AST_RD_ZERO: assert property (@(posedge CLK) disable iff (RST)
    !$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside read slot");

  // ----------------------------------------
  // Register checks
  // ----------------------------------------
  AST_RAW_REFUSE: assert property (@(posedge CLK)
    disable iff (RST) wr_raw && !raw_ok |=> raw == $past(raw))
    else $error("refused raw write changed the raw count");
  AST_RAW_TAKE: assert property (@(posedge CLK)
    disable iff (RST) take_raw && !busy |=> raw == $past(WDATA))
    else $error("legal raw write not loaded");
  AST_BASE_REFUSE: assert property (@(posedge CLK)
    disable iff (RST) wr_base && !base_ok |=> base == $past(base))
    else $error("refused base write changed the base");
  AST_BASE_TAKE: assert property (@(posedge CLK)
    disable iff (RST) take_base && !busy |=> base == $past(WDATA))
    else $error("legal base write not loaded");
  AST_BASE_RANGE: assert property (@(posedge CLK)
    disable iff (RST) base >= STEP && base <= MAX_US)
    else $error("time base outside its range");
  AST_DUR_REFUSE: assert property (@(posedge CLK)
    disable iff (RST) (wr_raw || wr_base || wr_abs) && !dur_ok |=>
    raw == $past(raw) && base == $past(base))
    else $error("write with illegal duration was taken");
  AST_ABS_ROUND: assert property (@(posedge CLK)
    disable iff (RST) take_abs && !busy && abs_raw > `ETL_RAW_MIN &&
    abs_raw < `ETL_RAW_MAX |=> (abs_us >= $past(WDATA) ?
    abs_us - $past(WDATA) : $past(WDATA) - abs_us) <= (base >> 1))
    else $error("absolute write not rounded to nearest");
  AST_ABS_RESET: assert property (@(posedge CLK)
    $fell(RST) |-> raw == `ETL_RAW_RESET &&
    abs_us == etl_mul(`ETL_RAW_RESET, BASE_RST))
    else $error("raw or absolute reset value wrong");
  AST_FREEZE: assert property (@(posedge CLK)
    disable iff (RST) busy |=> raw == $past(raw) && base == $past(base))
    else $error("settings changed during exposure");
  AST_RD_DATA: assert property (@(posedge CLK)
    disable iff (RST) $past(RD) |-> RDATA == $past(rd_mux))
    else $error("read data not the addressed register");

  // ----------------------------------------
  // Auto checks
  // ----------------------------------------
  AST_AUTO_FULL: assert property (@(posedge CLK)
    disable iff (RST) auto_en && AUTO_EXP_VALID && AUTO_EXP_US >= MIN_US &&
    AUTO_EXP_US <= MAX_US |=> auto_us == $past(AUTO_EXP_US))
    else $error("auto value was quantised");
  AST_AUTO_CLAMP: assert property (@(posedge CLK)
    disable iff (RST) $past(auto_en && AUTO_EXP_VALID) |->
    auto_us >= MIN_US && auto_us <= MAX_US)
    else $error("auto value outside the limits");
  AST_AUTO_HOLD: assert property (@(posedge CLK)
    disable iff (RST) !(auto_en && AUTO_EXP_VALID) |=> $stable(auto_us))
    else $error("auto value changed without a request");

  // ----------------------------------------
  // Timer checks
  // ----------------------------------------
  AST_DUR_EXACT: assert property (@(posedge CLK)
    disable iff (RST) state == ETL_TIMED && timed_end |->
    dur_cyc == etl_mul(etl_mul(goal_q, unit_q), US_CYC) - 32'h1)
    else $error("timed exposure length wrong");
  AST_DUR_CAP: assert property (@(posedge CLK)
    disable iff (RST) state == ETL_TIMED |-> dur_cyc < etl_mul(MAX_US, US_CYC))
    else $error("timed exposure past the maximum");
  AST_OVERTRIG: assert property (@(posedge CLK)
    disable iff (RST) state == ETL_TIMED && !timed_end |=> state == ETL_TIMED)
    else $error("timed exposure cut short");
  AST_EXPOSE_RISE: assert property (@(posedge CLK)
    disable iff (RST) start |=> EXPOSE)
    else $error("exposure did not start");
  AST_IDLE_STAY: assert property (@(posedge CLK)
    disable iff (RST) state == ETL_IDLE && !start |=> !EXPOSE)
    else $error("exposure without a start");
  AST_WIDTH_START: assert property (@(posedge CLK)
    disable iff (RST) trig_rise && !busy && width_mode |=> state == ETL_WIDTH)
    else $error("width exposure did not start on trigger");
  AST_WIDTH_HOLD: assert property (@(posedge CLK)
    disable iff (RST) state == ETL_WIDTH && EXTERNAL_ACQ_START_TRIGGER |=>
    EXPOSE)
    else $error("width exposure ended while trigger high");
  AST_TICK_TIMED: assert property (@(posedge CLK)
    disable iff (RST) tick |-> state == ETL_TIMED)
    else $error("time-base tick outside timed exposure");
  AST_GOAL_HELD: assert property (@(posedge CLK)
    disable iff (RST) state == ETL_TIMED |=>
    goal_q == $past(goal_q) && unit_q == $past(unit_q))
    else $error("latched length changed during exposure");
endmodule

/* bench/tb_exposure_time_setting_logic.sv */
`timescale 1ns/1ns
`include "etl_defines.svh"
module tb_exposure_time_setting_logic import etl_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic trig = 1'b0;
  logic [31:0] auto_us = 32'h0;
  logic auto_valid = 1'b0;
  logic expose;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int len;
  logic [31:0] us;
  logic [31:0] raw;

  etl_top i_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .EXTERNAL_ACQ_START_TRIGGER(trig),
    .AUTO_EXP_US(auto_us), .AUTO_EXP_VALID(auto_valid), .EXPOSE(expose));

  always #4 clk = ~clk;

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic conclude;
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask

  task automatic auto_chk(input logic [31:0] v, input logic [31:0] e);
    @(posedge clk);
    auto_us <= v;
    auto_valid <= 1'b1;
    @(posedge clk);
    auto_valid <= 1'b0;
    rd_chk(`ETL_REG_AUTO, e);
  endtask

  // Counts cycles with EXPOSE high; bounded so a stuck output cannot hang
  task automatic measure(output int n);
    int k;
    k = 0;
    n = 0;
    while (expose !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    while (expose === 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Allows two cycles of slack for the tick divider phase
  task automatic near(input int n, input int exp);
    check({31'h0, n >= exp - 2 && n <= exp + 2}, 32'h1);
  endtask

  function automatic logic [31:0] round_raw(input logic [31:0] u);
    return (u + `ETL_BASE_STD / 2) / `ETL_BASE_STD;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd1f8c1ce));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`ETL_REG_RAW, 32'h64);
    rd_chk(`ETL_REG_BASE, `ETL_BASE_STD);
    rd_chk(`ETL_REG_ABS, 32'h7d0);
    rd_chk(`ETL_REG_AUTO, 32'h18);
    rd_chk(4'h9, 32'h0);
    wr_reg(`ETL_REG_RAW, 32'h0);
    wr_reg(`ETL_REG_RAW, 32'h1000);
    rd_chk(`ETL_REG_RAW, 32'h64);
    wr_reg(`ETL_REG_RAW, `ETL_RAW_MAX);
    rd_chk(`ETL_REG_ABS, 32'hfff * `ETL_BASE_STD);
    wr_reg(`ETL_REG_RAW, 32'h1);
    rd_chk(`ETL_REG_RAW, `ETL_RAW_MAX);
    wr_reg(`ETL_REG_BASE, 32'h0);
    rd_chk(`ETL_REG_BASE, `ETL_BASE_STD);
    wr_reg(`ETL_REG_BASE, 32'h15);
    rd_chk(`ETL_REG_ABS, 32'hfff * 32'h15);
    wr_reg(`ETL_REG_BASE, `ETL_BASE_STD);
    repeat (6) begin
      raw = 32'h2 + $urandom % 32'hffd;
      wr_reg(`ETL_REG_RAW, raw);
      rd_chk(`ETL_REG_ABS, raw * `ETL_BASE_STD);
      us = 32'h28 + $urandom % 32'h13880;
      wr_reg(`ETL_REG_ABS, us);
      rd_chk(`ETL_REG_RAW, round_raw(us));
      rd_chk(`ETL_REG_ABS, round_raw(us) * `ETL_BASE_STD);
    end
    wr_reg(`ETL_REG_ABS, 32'h3f2);
    rd_chk(`ETL_REG_ABS, 32'h3fc);
    wr_reg(`ETL_REG_ABS, 32'ha);
    rd_chk(`ETL_REG_ABS, 32'h3fc);
    // Timed run with an overtrigger and a write that must be ignored
    wr_reg(`ETL_REG_RAW, 32'h2);
    @(posedge clk);
    trig <= 1'b1;
    fork
      measure(len);
      begin
        repeat (1000) @(posedge clk);
        trig <= 1'b0;
        wr_reg(`ETL_REG_RAW, 32'h5);
        trig <= 1'b1;
      end
    join
    near(len, 40 * 125);
    @(posedge clk);
    trig <= 1'b0;
    rd_chk(`ETL_REG_RAW, 32'h2);
    wr_reg(`ETL_REG_CTRL, 32'h2);
    auto_chk(32'h3f5, 32'h3f5);
    auto_chk(32'h5, 32'h18);
    auto_chk(32'h1312d00, `ETL_MAX_STD);
    // Auto length off the 20 us grid, started by the command bit
    auto_chk(32'h1d, 32'h1d);
    fork
      measure(len);
      begin
        wr_reg(`ETL_REG_CTRL, 32'h6);
        repeat (100) @(posedge clk);
        rd_chk(`ETL_REG_STATUS, 32'h3);
      end
    join
    near(len, 29 * 125);
    rd_chk(`ETL_REG_STATUS, 32'h2);
    wr_reg(`ETL_REG_CTRL, 32'h3);
    rd_chk(`ETL_REG_CTRL, 32'h1);
    @(posedge clk);
    trig <= 1'b1;
    fork
      measure(len);
      begin
        repeat (300) @(posedge clk);
        trig <= 1'b0;
      end
    join
    near(len, 300);
    conclude;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      conclude;
    end
  end
endmodule
